// ### src/scmr_defines.svh
/*
  constants for the serial configuration memory read-out block:
  register offsets, reset values, sizes and timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef SCMR_DEFINES_SVH
`define SCMR_DEFINES_SVH

// ---------------------------------------------------------------
// register word offsets
// ---------------------------------------------------------------
`define SCMR_OFS_CTRL      6'h00
`define SCMR_OFS_POLARITY  6'h01
`define SCMR_OFS_MEM_ADDR  6'h02
`define SCMR_OFS_MEM_DATA  6'h03
`define SCMR_OFS_STATUS    6'h04
`define SCMR_OFS_POSITION  6'h05

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define SCMR_CTRL_SIZE_BIT 0
`define SCMR_CTRL_SEL_BIT  1
`define SCMR_CTRL_RST      2'h1
`define SCMR_POL_RST       32'h00000000
`define SCMR_POL_INV_KEY   32'hFFFFFFFF
`define SCMR_RESP_OKAY     2'h0
`define SCMR_RESP_SLVERR   2'h2

// ---------------------------------------------------------------
// memory sizes
// ---------------------------------------------------------------
`define SCMR_MEM_BITS      1048576
`define SCMR_LAST_1M       20'hFFFFF
`define SCMR_LAST_512K     20'h7FFFF
`define SCMR_HALF_1M       20'h80000
`define SCMR_HALF_512K     20'h40000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SCMR_CLK_PERIOD_NS 10
`define SCMR_POR_TIME_NS   200
`define SCMR_POR_CYCLES \
  ((`SCMR_POR_TIME_NS + `SCMR_CLK_PERIOD_NS - 1) / `SCMR_CLK_PERIOD_NS)
`define SCMR_POR_CNT_W     8

`endif

// ### src/scmr_pkg.sv
/*
  types shared by the read-out block.
  assumes scmr_defines.svh supplies the numbers.
*/
package scmr_pkg;

  typedef enum logic [0:0] {
    SCMR_ST_POR = 1'b0,
    SCMR_ST_RUN = 1'b1
  } scmr_state_e;

  typedef logic [19:0] scmr_idx_t;

endpackage

// ### src/scmr_readout.sv
/*
  serial configuration memory read-out: bit counter, chain enable,
  power-up ready, programmable clear polarity, axi4-lite registers.
  assumes all pins are asynchronous to core_clk and the config clock
  is far slower than core_clk.
*/
// Added by the designer: the register offsets and the AXI4-Lite slave port.
//
// Behaviour
// RULE1: one-bit memory of 512k or 1M bits
// RULE2: clear level clears address and bit counters
// RULE3: drive data only when enabled and chain-in low
// RULE4: four stored bytes select clear polarity
// RULE5: each clock advances address and bit counter
// RULE6: advance only with chain-in low, gate enabled
// RULE7: chain-in high freezes counters, enters standby
// RULE8: clear level floats data regardless of chain-in
// RULE9: chain-out low once counter reaches maximum
// RULE10: after last bit, release data line
// RULE11: chain-out low, follows chain-in, high until reread
// RULE12: chain-out feeds next device chain-in
// RULE13: power-up clears address counter automatically
// RULE14: ready pulled low during power-up, then released
// RULE15: gate rules only with program select high
// RULE16: device select decides programming response
// RULE17: write protects guard programming only
// RULE18: data three-state reading, open-collector programming
// RULE19: accept in-system programming of memory
// RULE20: program select held high outside programming
// RULE21: chain-in low from previous enables own data
// RULE22: present current bit, advance on rising edge
// RULE23: master holds enables, clocks, samples each bit
`timescale 1ns/1ps
`include "scmr_defines.svh"

module scmr_readout (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // configuration link pins
  input  wire logic        fpga_config_clock,
  input  wire logic        chain_enable_in_n,
  input  wire logic        counter_clear_gate,
  output logic             chain_enable_out_n,
  input  wire logic        data_i,
  output logic             data_o,
  output logic             data_oe,
  // programming and status pins
  input  wire logic        serial_program_select,
  input  wire logic        protect_pin_one,
  input  wire logic        protect_pin_two,
  input  wire logic        device_select_bit,
  output logic             ready_o,
  output logic             ready_oe,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pin_raw = {data_i, device_select_bit, protect_pin_two,
                    protect_pin_one, serial_program_select,
                    counter_clear_gate, chain_enable_in_n,
                    fpga_config_clock};

  // first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic fpga_config_clock_s, ce_n_s, gate_s, prog_sel_s;
  logic wp1_s, wp2_s, dev_sel_s, data_in_s;
  logic fpga_config_clock_prev_q;
  logic fpga_config_clock_rise;

  assign fpga_config_clock_s     = sync2_q[0];
  assign ce_n_s     = sync2_q[1];
  assign gate_s     = sync2_q[2];
  assign prog_sel_s = sync2_q[3];
  assign wp1_s      = sync2_q[4];
  assign wp2_s      = sync2_q[5];
  assign dev_sel_s  = sync2_q[6];
  assign data_in_s  = sync2_q[7];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fpga_config_clock_prev_q <= 1'b0;
    end else begin
      fpga_config_clock_prev_q <= fpga_config_clock_s;
    end
  end
  assign fpga_config_clock_rise = fpga_config_clock_s & ~fpga_config_clock_prev_q; // RULE22

  // ---------------------------------------------------------------
  // registers and mode decode
  // ---------------------------------------------------------------
  logic [1:0]        ctrl_q;
  logic [31:0]       pol_q;
  scmr_pkg::scmr_idx_t prog_addr_q;
  logic              prog_reject_q;
  logic              pol_inv;
  logic              gate_en;
  logic              read_mode;
  scmr_pkg::scmr_idx_t last_idx;
  scmr_pkg::scmr_idx_t half_idx;

  // clear polarity inverts only when all four bytes hold the key
  assign pol_inv   = (pol_q == `SCMR_POL_INV_KEY); // RULE4
  assign gate_en   = pol_inv ? ~gate_s : gate_s; // RULE4
  assign read_mode = prog_sel_s; // RULE15 RULE20
  assign last_idx  = ctrl_q[`SCMR_CTRL_SIZE_BIT] ? `SCMR_LAST_1M
                                                 : `SCMR_LAST_512K; // RULE1
  assign half_idx  = ctrl_q[`SCMR_CTRL_SIZE_BIT] ? `SCMR_HALF_1M
                                                 : `SCMR_HALF_512K;

  // ---------------------------------------------------------------
  // power-up sequence
  // ---------------------------------------------------------------
  scmr_pkg::scmr_state_e        state_q;
  logic [`SCMR_POR_CNT_W-1:0]   por_cnt_q;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= scmr_pkg::SCMR_ST_POR;
      por_cnt_q <= '0;
    end else begin
      unique case (state_q)
        scmr_pkg::SCMR_ST_POR: begin
          por_cnt_q <= por_cnt_q + 1'b1;
          if (por_cnt_q == `SCMR_POR_CNT_W'(`SCMR_POR_CYCLES - 1)) begin
            state_q <= scmr_pkg::SCMR_ST_RUN;
          end
        end
        scmr_pkg::SCMR_ST_RUN: begin
          state_q <= scmr_pkg::SCMR_ST_RUN;
        end
      endcase
    end
  end

  // open collector: only ever pulls low
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ready_o  <= 1'b0;
      ready_oe <= 1'b1;
    end else begin
      ready_o  <= 1'b0;
      ready_oe <= (state_q == scmr_pkg::SCMR_ST_POR); // RULE14
    end
  end

  // ---------------------------------------------------------------
  // address and bit counters, chain enable
  // ---------------------------------------------------------------
  logic [16:0] addr_q;
  logic [2:0]  bit_q;
  logic        done_q;
  scmr_pkg::scmr_idx_t pos;

  assign pos = {addr_q, bit_q};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= '0;
      bit_q  <= '0;
      done_q <= 1'b0;
    end else if (state_q == scmr_pkg::SCMR_ST_POR) begin
      addr_q <= '0; // RULE13
      bit_q  <= '0;
      done_q <= 1'b0;
    end else if (read_mode) begin
      if (!gate_en) begin
        addr_q <= '0; // RULE2 RULE8
        bit_q  <= '0;
        done_q <= 1'b0;
      end else if (!ce_n_s && fpga_config_clock_rise && !done_q) begin // RULE6 RULE7
        if (pos == last_idx) begin
          done_q <= 1'b1; // RULE9
        end else begin
          {addr_q, bit_q} <= pos + 1'b1; // RULE5 RULE22
        end
      end
    end
  end

  // low after the last bit while chained in; high again after clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chain_enable_out_n <= 1'b1;
    end else begin
      chain_enable_out_n <= ~(read_mode && gate_en && done_q
                              && !ce_n_s); // RULE11 RULE9
    end
  end

  // ---------------------------------------------------------------
  // memory and data pin
  // ---------------------------------------------------------------
  logic mem [0:`SCMR_MEM_BITS-1]; // RULE1
  logic prog_ok;
  logic mem_wr;
  logic prog_ack_q;
  logic standby_q;

  // protect pins split the selected size in halves
  assign prog_ok = !read_mode && state_q == scmr_pkg::SCMR_ST_RUN
                && (dev_sel_s == ctrl_q[`SCMR_CTRL_SEL_BIT]) // RULE16
                && (prog_addr_q <= last_idx)
                && !(wp1_s && prog_addr_q < half_idx) // RULE17
                && !(wp2_s && prog_addr_q >= half_idx); // RULE17

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_o     <= 1'b0;
      data_oe    <= 1'b0;
      prog_ack_q <= 1'b0;
      standby_q  <= 1'b0;
    end else begin
      prog_ack_q <= mem_wr;
      standby_q  <= read_mode && ce_n_s; // RULE7
      if (read_mode) begin
        data_o  <= mem[pos]; // RULE22
        data_oe <= state_q == scmr_pkg::SCMR_ST_RUN && gate_en
                && !ce_n_s && !done_q; // RULE3 RULE10 RULE21 RULE18
      end else begin
        data_o  <= 1'b0; // RULE18
        data_oe <= prog_ack_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic [5:0] aw_word_q;
  logic       aw_full_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_full_q;
  logic        wr_fire;
  logic [5:0]  ar_word;

  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign ar_word = s_axi_araddr[7:2];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      aw_full_q     <= 1'b0;
      aw_word_q     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full_q     <= 1'b1;
      aw_word_q     <= s_axi_awaddr[7:2];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_full_q     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      w_full_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full_q     <= 1'b1;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_full_q     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SCMR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_word_q <= `SCMR_OFS_POSITION) ? `SCMR_RESP_OKAY
                                                       : `SCMR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q      <= `SCMR_CTRL_RST;
      pol_q       <= `SCMR_POL_RST;
      prog_addr_q <= '0;
    end else if (wr_fire) begin
      if (aw_word_q == `SCMR_OFS_CTRL && wstrb_q[0]) begin
        ctrl_q <= wdata_q[1:0];
      end
      if (aw_word_q == `SCMR_OFS_POLARITY) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) begin
            pol_q[8*b +: 8] <= wdata_q[8*b +: 8]; // RULE4
          end
        end
      end
      if (aw_word_q == `SCMR_OFS_MEM_ADDR) begin
        prog_addr_q <= wdata_q[19:0];
      end
      if (mem_wr) begin
        prog_addr_q <= prog_addr_q + 1'b1;
      end
    end
  end

  // programming path; a refused write leaves memory untouched
  assign mem_wr = wr_fire && aw_word_q == `SCMR_OFS_MEM_DATA
               && wstrb_q[0] && prog_ok; // RULE19

  always_ff @(posedge core_clk) begin
    if (mem_wr) begin
      mem[prog_addr_q] <= wdata_q[0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prog_reject_q <= 1'b0;
    end else if (wr_fire && aw_word_q == `SCMR_OFS_MEM_DATA) begin
      prog_reject_q <= !mem_wr;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SCMR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SCMR_RESP_OKAY;
      s_axi_rdata   <= '0;
      unique case (ar_word)
        `SCMR_OFS_CTRL:     s_axi_rdata[1:0] <= ctrl_q;
        `SCMR_OFS_POLARITY: s_axi_rdata <= pol_q;
        `SCMR_OFS_MEM_ADDR: s_axi_rdata[19:0] <= prog_addr_q;
        `SCMR_OFS_MEM_DATA: s_axi_rdata[0] <= mem[prog_addr_q];
        `SCMR_OFS_STATUS: begin
          s_axi_rdata[5:0] <= {data_in_s, prog_reject_q, !read_mode,
                               standby_q, done_q,
                               state_q == scmr_pkg::SCMR_ST_RUN};
        end
        `SCMR_OFS_POSITION: s_axi_rdata[19:0] <= pos;
        default:            s_axi_rresp <= `SCMR_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // scmr_readout

// ### sim/scmr_readout_checker.sv
/* checker: port-level properties of scmr_readout.
   assumes it is bound onto every scmr_readout instance. */
`timescale 1ns/1ps
module scmr_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // link and status pins
  input wire logic        chain_enable_in_n,
  input wire logic        serial_program_select,
  input wire logic        chain_enable_out_n,
  input wire logic        data_o,
  input wire logic        data_oe,
  input wire logic        ready_o,
  input wire logic        ready_oe,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ---------------------------------------------------------------
  // power-up cycle counter, saturating so it never wraps
  // ---------------------------------------------------------------
  logic [4:0] por_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) por_q <= 5'h00;
    else if (por_q != 5'h1F) por_q <= por_q + 5'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_POR_HOLD: assert property (por_q < 5'h12 |-> ready_oe)
    else $error("ready released early");
  AST_POR_FREE: assert property (por_q > 5'h18 |-> !ready_oe)
    else $error("ready still held");
  AST_READY_OC: assert property (ready_oe |-> !ready_o)
    else $error("ready driven high");
  AST_STANDBY: assert property ((chain_enable_in_n
    && serial_program_select) [*8] |-> !data_oe)
    else $error("data driven in standby");
  AST_DONE_FLOAT: assert property (!chain_enable_out_n
    && serial_program_select |-> !data_oe)
    else $error("data driven after chain out");
  AST_OC_ACK: assert property (data_oe && !serial_program_select
    && $past(!serial_program_select, 8) |-> !data_o ##1 !data_oe)
    else $error("ack not open collector pulse");
  AST_B_LAT: assert property (wr_both |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_ERR: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > 8'h17 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  C_WRITE: cover property (wr_both);
  C_ACK: cover property (data_oe && !serial_program_select);
  C_STREAM: cover property ((data_oe && serial_program_select) [*8]);
endmodule // scmr_checker

bind scmr_readout scmr_checker chk (.core_clk, .resetn,
  .chain_enable_in_n, .serial_program_select, .chain_enable_out_n,
  .data_o, .data_oe, .ready_o, .ready_oe, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);

// ### sim/scmr_fpga_master.sv
/* configuration master model: clocks bits out of the block and
   samples the data line before each rising clock.
   assumes the bench resolves the data line and feeds it in. */
`timescale 1ns/1ps
module scmr_fpga_master (
  // clock
  input wire logic core_clk,
  // link
  input wire logic data_line,
  output logic     fpga_config_clock,
  output logic     chain_enable_in_n,
  output logic     counter_clear_gate
);
  // ---------------------------------------------------------------
  // frames: link clock runs only inside them, phase free of core_clk
  // ---------------------------------------------------------------
  logic [15:0] got;
  initial begin
    fpga_config_clock = 1'b0;
    chain_enable_in_n = 1'b1;
    counter_clear_gate = 1'b0;
    got = 16'h0000;
  end
  task automatic frame(input logic lvl, input logic ce, input int n);
    @(posedge core_clk);
    counter_clear_gate <= lvl;
    chain_enable_in_n <= ce;
    #103;
    for (int i = 0; i < n; i++) begin
      got[i] = data_line;
      fpga_config_clock = 1'b1;
      #62.5;
      fpga_config_clock = 1'b0;
      #62.5;
    end
  endtask
endmodule // scmr_fpga_master

// ### sim/tb.sv
/* bench for scmr_readout: bus tasks, a master model on the link,
   checks on programming, read-out, standby, clear and polarity.
   assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk, resetn, alt, chain_enable_out_n, data_o, data_oe;
  logic fpga_config_clock, chain_enable_in_n, counter_clear_gate;
  logic serial_program_select, device_select_bit, ready_o, ready_oe;
  logic protect_pin_one, protect_pin_two;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          err_total, n_compared;
  logic [15:0] pat;
  // released data line shows a changing pattern, ready has a pull-up
  wire data_line = data_oe ? data_o : alt;
  wire ready_line = ready_oe ? ready_o : 1'b1;
  scmr_readout uut (.core_clk, .resetn, .fpga_config_clock,
    .chain_enable_in_n, .counter_clear_gate, .chain_enable_out_n,
    .data_i(data_line), .data_o, .data_oe, .serial_program_select,
    .protect_pin_one, .protect_pin_two, .device_select_bit, .ready_o,
    .ready_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  scmr_fpga_master fm (.core_clk, .data_line, .fpga_config_clock,
    .chain_enable_in_n, .counter_clear_gate);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) alt <= ~alt;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    end_sim();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 100) hang();
  endtask
  task automatic rdr(input logic [7:0] a);
    int k;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 100) hang();
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {resetn, alt, device_select_bit, s_axi_awvalid} = 4'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {protect_pin_one, protect_pin_two} = 2'h0;
    serial_program_select = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    err_total = 0;
    n_compared = 0;
    pat = 16'hA5C3;
    cyc(2);
    resetn <= 1'b1;
    @(posedge core_clk);
    `CHK(ready_oe, 1'b1)
    rdr(8'h10);
    `CHK(rd[0], 1'b0)
    cyc(30);
    `CHK(ready_line, 1'b1)
    rdr(8'h10);
    `CHK(rd[2:0], 3'h5)
    rdr(8'h14);
    `CHK(rd[19:0], 20'h00000)
    rdr(8'h00);
    `CHK(rd[1:0], 2'h1)
    rdr(8'h04);
    `CHK(rd, 32'h00000000)
    rdr(8'h18);
    `CHK(rs, 2'h2)
    wr(8'h18, 32'h00000001);
    `CHK(rs, 2'h2)
    $display("test reset done");
    serial_program_select <= 1'b0;
    cyc(4);
    wr(8'h08, 32'h00000000);
    for (int i = 0; i < 16; i++) wr(8'h0C, {31'h0, pat[i]});
    rdr(8'h08);
    `CHK(rd[19:0], 20'h00010)
    rdr(8'h10);
    `CHK(rd[4:3], 2'h1)
    device_select_bit <= 1'b1;
    cyc(4);
    wr(8'h08, 32'h00000000);
    wr(8'h0C, {31'h0, ~pat[0]});
    rdr(8'h10);
    `CHK(rd[4], 1'b1)
    device_select_bit <= 1'b0;
    protect_pin_one <= 1'b1;
    cyc(4);
    wr(8'h0C, {31'h0, ~pat[0]});
    rdr(8'h10);
    `CHK(rd[4], 1'b1)
    rdr(8'h0C);
    `CHK(rd[0], pat[0])
    $display("test programming done");
    serial_program_select <= 1'b1;
    cyc(4);
    fm.frame(1'b1, 1'b0, 8);
    `CHK(fm.got[7:0], pat[7:0])
    `CHK(data_oe, 1'b1)
    `CHK(chain_enable_out_n, 1'b1)
    rdr(8'h14);
    `CHK(rd[19:0], 20'h00008)
    fm.frame(1'b1, 1'b1, 4);
    `CHK(data_oe, 1'b0)
    rdr(8'h14);
    `CHK(rd[19:0], 20'h00008)
    fm.frame(1'b1, 1'b0, 8);
    `CHK(fm.got[7:0], pat[15:8])
    fm.frame(1'b0, 1'b1, 0);
    cyc(8);
    `CHK(data_oe, 1'b0)
    rdr(8'h14);
    `CHK(rd[19:0], 20'h00000)
    $display("test read-out done");
    wr(8'h04, 32'hFFFFFFFF);
    rdr(8'h04);
    `CHK(rd, 32'hFFFFFFFF)
    fm.frame(1'b0, 1'b0, 8);
    `CHK(fm.got[7:0], pat[7:0])
    fm.frame(1'b1, 1'b0, 0);
    cyc(8);
    `CHK(data_oe, 1'b0)
    rdr(8'h14);
    `CHK(rd[19:0], 20'h00000)
    $display("test polarity done");
    end_sim();
  end
endmodule // tb
